//--- test/pph_board_model.sv
// Purpose: Board-side driver of the dedicated input and I/O pins.
// Assumes: Bench changes levels and release masks just after a clock edge.
// Notes: A released pin shows the inverse of its last driven level.
`timescale 1ns/100ps
`default_nettype none
module pph_board_model (
  // Clock
  input wire logic mclk,
  // Bench commands, I/O pins above inputs
  input wire logic [21:0] drv,
  input wire logic [21:0] rel,
  // Pins
  output logic [11:0] pinIn,
  output logic [11:0] pinFloat,
  output logic [9:0] ioIn,
  output logic [9:0] ioFloat
);
  // ==========================================================
  // Pin levels
  // ==========================================================
  logic [21:0] lastQ; // Last driven level of each pin
  // Remember the level of every pin still driven
  always_ff @(posedge mclk) begin
    lastQ <= (lastQ & rel) | (drv & ~rel);
  end
  // Undriven pins never show a stale copy, so the keeper must act
  assign {ioIn, pinIn} = (drv & ~rel) | (~lastQ & rel);
  assign {ioFloat, pinFloat} = rel;
endmodule : pph_board_model
`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench for the power-down hold block.
// Assumes: 200 MHz mclk; AXI4-Lite master holds bready and rready high.
// Notes: Random values from a fixed seed, with sleep and security corners.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals
  // ==========================================================
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [pph_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleeping;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [11:0] pinIn, pinFloat;
  logic [9:0] ioIn, ioFloat, ioOut, ioOe_n, pol, sum, out, oe;
  logic [9:0] sumTerm = '0, oeTerm = '0;
  logic [21:0] arrayIn, ai, drv = '0, rel = '0;
  int fail_count = 0, checked = 0, n;
  // Clock at 5 ns period
  always #2.5 mclk = ~mclk;
  // Block under test and board
  pph_top i_pph_top (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinFloat, .ioIn, .ioFloat,
    .ioOut, .ioOe_n, .arrayIn, .sumTerm, .oeTerm, .sleeping);
  pph_board_model i_pph_board_model (.mclk, .drv, .rel, .pinIn, .pinFloat, .ioIn, .ioFloat);
  // ==========================================================
  // Tasks
  // ==========================================================
  // Verdict and end of run
  task automatic conclude;
    $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait ran out
  task automatic hang(input int k);
    if (k >= 64) begin
      fail_count++;
      conclude();
    end
  endtask : hang
  // One AXI4-Lite write, both halves offered together
  task automatic axiWr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    hang(n);
  endtask : axiWr
  // One AXI4-Lite read, then compare data and response
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    hang(n);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rdChk
  // Wait for the hold flag, bounded
  task automatic waitSleep(input logic v);
    for (n = 0; n < 64 && sleeping !== v; n++) @(posedge mclk);
    hang(n);
  endtask : waitSleep
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    d = $urandom(50);
    oeTerm <= 10'($urandom);
    // Clock pin stays low through reset and power-up interval
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rdChk(pph_pkg::STAT_OFS, 32'h2, pph_pkg::RESP_OKAY);
    repeat (205) @(posedge mclk);
    // Combinational path with random polarity, pins straight to the array
    for (int i = 0; i < 4; i++) begin
      pol = 10'($urandom);
      sum = 10'($urandom);
      axiWr(pph_pkg::MCFG_OFS, {22'h0, pol});
      rdChk(pph_pkg::MCFG_OFS, {22'h0, pol}, pph_pkg::RESP_OKAY);
      sumTerm <= sum;
      drv <= 22'($urandom) & 22'h3ffffe;
      repeat (6) @(posedge mclk);
      chk(32'(ioOut), 32'(sum ^ pol));
      chk(32'(arrayIn), 32'(drv));
    end
    $display("Combinational path test done");
    // Registered path: low from power-up until the first clock-pin edge
    axiWr(pph_pkg::MCFG_OFS, {6'h0, 10'h3ff, 6'h0, pol});
    repeat (4) @(posedge mclk);
    chk(32'(ioOut), 32'(pol));
    drv[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(ioOut), 32'(sum ^ pol));
    chk(32'(arrayIn[21:12]), 32'(sum));
    $display("Registered path test done");
    // Hold: everything frozen while inputs, clock pin and pins change
    axiWr(pph_pkg::CTRL_OFS, 32'h1);
    drv[1] <= 1'b1;
    waitSleep(1'b1);
    chk(32'(sleeping), 32'h1);
    out = ioOut;
    oe = ioOe_n;
    ai = arrayIn;
    sum = ~sum;
    sumTerm <= sum;
    oeTerm <= ~oeTerm;
    drv <= {~drv[21:2], 1'b1, 1'b0};
    rel <= 22'h3f0000;
    repeat (12) @(posedge mclk);
    chk(32'(ioOut), 32'(out));
    chk(32'(ioOe_n), 32'(oe));
    chk(32'(arrayIn), 32'(ai));
    chk(32'(arrayIn[1]), 32'h0);
    rdChk(pph_pkg::STAT_OFS, {6'h0, out, 15'h0, 1'b1}, pph_pkg::RESP_OKAY);
    drv[1] <= 1'b0;
    waitSleep(1'b0);
    chk(32'(sleeping), 32'h0);
    repeat (5) @(posedge mclk);
    drv[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(ioOut), 32'(sum ^ pol));
    oe = ~oeTerm;
    chk(32'(ioOe_n), 32'(oe));
    $display("Sleep and resume test done");
    // Released inputs keep their last driven level
    rel <= 22'h3f0fff;
    repeat (6) @(posedge mclk);
    chk(32'(arrayIn[11:0]), 32'(drv[11:0] & 12'hffd));
    chk(32'(sleeping), 32'h0);
    $display("Keeper test done");
    // Security hides configuration, signature stays readable
    d = $urandom;
    axiWr(pph_pkg::SIGLO_OFS, d);
    chk(32'(r), 32'(pph_pkg::RESP_OKAY));
    axiWr(pph_pkg::SIGHI_OFS, ~d);
    axiWr(pph_pkg::CTRL_OFS, 32'h3);
    rdChk(pph_pkg::CTRL_OFS, 32'h2, pph_pkg::RESP_OKAY);
    rdChk(pph_pkg::MCFG_OFS, 32'h0, pph_pkg::RESP_OKAY);
    rdChk(pph_pkg::SIGLO_OFS, d, pph_pkg::RESP_OKAY);
    rdChk(pph_pkg::SIGHI_OFS, ~d, pph_pkg::RESP_OKAY);
    axiWr(8'h20, 32'hffff_ffff);
    chk(32'(r), 32'(pph_pkg::RESP_SLVERR));
    rdChk(8'h20, 32'h0, pph_pkg::RESP_SLVERR);
    $display("Security test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire

//--- verilog/pph_pin_keeper.sv
// Purpose: Weak keeper for a group of pins, holding the last driven level.
// Assumes: Level and float inputs are already synchronised to mclk.
// Notes: A hold freezes the sampled level while the keeper stays in force.
`timescale 1ns/100ps
`default_nettype none
module pph_pin_keeper #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Pin side
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] floating,
  // Control
  input wire logic hold,
  // Logic side
  output logic [WIDTH-1:0] kept
);
  // ==========================================================
  // Keeper state
  // ==========================================================
  logic [WIDTH-1:0] kept_q;  // Last accepted level per pin

  // Follow a driven pin, keep the old level on a floating one
  always_ff @(posedge mclk) begin
    if (srst) begin
      kept_q <= '0;
    end else if (!hold) begin
      kept_q <= (level & ~floating) | (kept_q & floating);
    end
  end

  assign kept = kept_q;

  // Floating pin 0 never changes its kept level
  property keepFloat_p;
    @(posedge mclk) disable iff (srst) (floating[0] && !hold) |=> $stable(kept_q[0]);
  endproperty
  floatKeep_a: assert property (keepFloat_p) else $error("keeper lost level");
  // Held keeper stays put
  holdKeep_a: assert property (@(posedge mclk) disable iff (srst)
    hold |=> $stable(kept_q)) else $error("keeper moved during hold");
endmodule : pph_pin_keeper
`default_nettype wire

//--- verilog/pph_pkg.sv
// Purpose: Shared constants and types for the power-down hold block.
// Assumes: 200 MHz mclk; AXI4-Lite register access with 32-bit data.
// Notes: All offsets, field positions, the signature reset value and counts live here.
package pph_pkg;
  // ==========================================================
  // Device shape
  // ==========================================================
  localparam int NUM_IN = 12;               // Dedicated inputs
  localparam int NUM_MC = 10;               // I/O macrocells
  localparam int ARRAY_W = NUM_IN + NUM_MC; // Product-term array inputs
  localparam int CLK_PIN_IDX = 0;           // Input pin that clocks the macrocells
  localparam int SHARED_PIN_IDX = 1;        // Input pin shared with the sleep function
  localparam int ADDR_W = 8;                // Register bus address width

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 200;                 // mclk rate
  localparam int POWERUP_RESET_TIME_NS = 1000;  // Longest power-up reset time
  // Longest time, so the cycle count rounds down
  localparam int POWERUP_RESET_CYCLES = (POWERUP_RESET_TIME_NS * CLK_MHZ) / 1000;
  localparam int POR_CNT_W = 8;                 // Width of the power-up counter

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;   // Sleep enable, security
  localparam logic [ADDR_W-1:0] MCFG_OFS = 8'h04;   // Macrocell configuration
  localparam logic [ADDR_W-1:0] SIGLO_OFS = 8'h08;  // User signature, low word
  localparam logic [ADDR_W-1:0] SIGHI_OFS = 8'h0c;  // User signature, high word
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h10;   // Block state
  localparam int CTRL_SLEEP_EN_BIT = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam int MCFG_POL_LSB = 0;     // Ten active-low bits
  localparam int MCFG_REG_LSB = 16;    // Ten registered-path bits
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_POR_BIT = 1;
  localparam int STAT_OUT_LSB = 16;    // Ten output levels
  localparam logic [31:0] SIG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  // Per-macrocell output form
  typedef struct packed {
    logic [NUM_MC-1:0] registered;  // 1: registered path, 0: combinational
    logic [NUM_MC-1:0] activeLow;   // 1: inverted output
  } pph_mc_cfg_t;

  // Device-wide control bits
  typedef struct packed {
    logic secure;   // Blocks configuration readback, sticky
    logic sleepEn;  // Shared pin acts as sleep pin
  } pph_ctrl_t;

  // Power sequencing states
  typedef enum logic [1:0] {
    PS_PORWAIT,
    PS_RUN,
    PS_SLEEP
  } pph_pwr_state_t;
endpackage : pph_pkg

//--- verilog/pph_top.sv
// Purpose: Power-down hold, pin keepers, macrocell outputs and signature.
// Assumes: Product-term array sits outside; pins are asynchronous to mclk.
// Notes: Registers on AXI4-Lite; security bit is sticky until reset.
//
// Summary of operation
// - Enabled and sleep pin high enters hold
// - Hold freezes registers and output values
// - Undetermined outputs stay as they were
// - Hold blocks all inputs except sleep pin
// - Pin keepers stay active while holding
// - Undriven pins keep last level, weakly
// - One bit selects sleep; default plain input
// - Sleep use hides pin from array
// - Twelve inputs, ten macrocells feed array
// - Macrocell polarity and registered/combinational path
// - Security blocks readback; signature always readable
// - Power-up clears macrocell registers low
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pph_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [pph_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [pph_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Dedicated input pins
  input wire logic [pph_pkg::NUM_IN-1:0] pinIn,
  input wire logic [pph_pkg::NUM_IN-1:0] pinFloat,
  // Macrocell I/O pins
  input wire logic [pph_pkg::NUM_MC-1:0] ioIn,
  input wire logic [pph_pkg::NUM_MC-1:0] ioFloat,
  output logic [pph_pkg::NUM_MC-1:0] ioOut,
  output logic [pph_pkg::NUM_MC-1:0] ioOe_n,
  // Product-term array
  output logic [pph_pkg::ARRAY_W-1:0] arrayIn,
  input wire logic [pph_pkg::NUM_MC-1:0] sumTerm,
  input wire logic [pph_pkg::NUM_MC-1:0] oeTerm,
  // Status
  output logic sleeping
);
  localparam int SYNC_W = 2 * (pph_pkg::NUM_IN + pph_pkg::NUM_MC);

  // ==========================================================
  // Declarations
  // ==========================================================
  pph_pkg::pph_ctrl_t ctrl_q;          // Sleep enable and security
  pph_pkg::pph_mc_cfg_t mcCfg_q;       // Output forms
  logic [63:0] sig_q;                  // User signature
  pph_pkg::pph_pwr_state_t pwr_q;      // Power sequencing state
  logic [pph_pkg::POR_CNT_W-1:0] porCnt_q;  // Power-up reset interval counter, counting up
  logic [SYNC_W-1:0] syncA_q;          // First synchroniser stage
  logic [SYNC_W-1:0] syncB_q;          // Second synchroniser stage
  logic [pph_pkg::NUM_IN-1:0] keptIn;  // Kept dedicated inputs
  logic [pph_pkg::NUM_MC-1:0] keptIo;  // Kept I/O pin levels
  logic clkPrev_q;                     // Previous level of the clock pin
  logic clkEdge;                       // Rising edge seen on the clock pin
  logic sleepReq;                      // Sleep requested by the shared pin
  logic holdNow;                       // Hold state in force
  logic porBusy;                       // Power-up reset interval running
  logic [pph_pkg::NUM_MC-1:0] mcReg_q; // Macrocell registers
  logic [pph_pkg::NUM_MC-1:0] out_q;   // Output levels
  logic [pph_pkg::NUM_MC-1:0] oeN_q;   // Output enables, low drives
  logic [pph_pkg::NUM_MC-1:0] pathVal; // Selected path before polarity
  logic [pph_pkg::NUM_MC-1:0] feedback;// Feedback into the array
  logic [pph_pkg::NUM_IN-1:0] arrIn;   // Input half of the array inputs
  logic [pph_pkg::ADDR_W-1:0] awAddr_q;// Held write address
  logic awHeld_q;                      // Write address taken
  logic [31:0] wData_q;                // Held write data
  logic [3:0] wStrb_q;                 // Held byte enables
  logic wHeld_q;                       // Write data taken
  logic bValid_q;                      // Write response pending
  logic [1:0] bResp_q;                 // Write response code
  logic rValid_q;                      // Read data pending
  logic [1:0] rResp_q;                 // Read response code
  logic [31:0] rData_q;                // Read data
  logic doWrite;                       // Both halves of a write present
  logic [31:0] rdMux;                  // Read data for the current address
  logic rdHit;                         // Read address is mapped
  logic wrHit;                         // Write address is mapped
  logic sleepKept;                     // Kept level of the shared sleep pin
  logic [31:0] mcfgOld;                // Output forms as a register word
  logic [31:0] mcfgNew;                // Same word with the held write merged

  // Byte-enable merge of held data into an old word
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // ==========================================================
  // Pin synchronisers and keepers
  // ==========================================================
  // Two flops ahead of any logic for every pin signal
  always_ff @(posedge mclk) begin
    if (srst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {pinFloat, pinIn, ioFloat, ioIn};
      syncB_q <= syncA_q;
    end
  end

  // Dedicated inputs keep their level and are blocked while holding
  pph_pin_keeper #(.WIDTH(pph_pkg::NUM_IN)) inKeep (
    .mclk(mclk),
    .srst(srst),
    .level(syncB_q[2*pph_pkg::NUM_MC +: pph_pkg::NUM_IN]),
    .floating(syncB_q[2*pph_pkg::NUM_MC+pph_pkg::NUM_IN +: pph_pkg::NUM_IN]),
    .hold(holdNow),
    .kept(keptIn)
  );

  // I/O pins keep their level likewise
  pph_pin_keeper #(.WIDTH(pph_pkg::NUM_MC)) ioKeep (
    .mclk(mclk),
    .srst(srst),
    .level(syncB_q[0 +: pph_pkg::NUM_MC]),
    .floating(syncB_q[pph_pkg::NUM_MC +: pph_pkg::NUM_MC]),
    .hold(holdNow),
    .kept(keptIo)
  );

  // Sleep pin keeps its level when undriven, but is never frozen so it can end the hold
  pph_pin_keeper #(.WIDTH(1)) sleepKeep (
    .mclk(mclk),
    .srst(srst),
    .level(syncB_q[2*pph_pkg::NUM_MC + pph_pkg::SHARED_PIN_IDX]),
    .floating(syncB_q[2*pph_pkg::NUM_MC + pph_pkg::NUM_IN + pph_pkg::SHARED_PIN_IDX]),
    .hold(1'b0),
    .kept(sleepKept)
  );

  assign sleepReq = ctrl_q.sleepEn & sleepKept;

  // ==========================================================
  // Power sequencing
  // ==========================================================
  // Wait out power-up reset, then follow the sleep pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      pwr_q <= pph_pkg::PS_PORWAIT;
      porCnt_q <= '0;
    end else begin
      case (pwr_q)
        pph_pkg::PS_PORWAIT: begin
          // Clock pin ignored until the interval is over
          if (porCnt_q == pph_pkg::POR_CNT_W'(pph_pkg::POWERUP_RESET_CYCLES - 1)) begin
            pwr_q <= pph_pkg::PS_RUN;
          end else begin
            porCnt_q <= porCnt_q + 1'b1;
          end
        end
        pph_pkg::PS_RUN: begin
          if (sleepReq) begin
            pwr_q <= pph_pkg::PS_SLEEP;
          end
        end
        pph_pkg::PS_SLEEP: begin
          if (!sleepReq) begin
            pwr_q <= pph_pkg::PS_RUN;
          end
        end
        default: begin
          pwr_q <= pph_pkg::PS_PORWAIT;
        end
      endcase
    end
  end

  assign holdNow = (pwr_q == pph_pkg::PS_SLEEP);
  assign porBusy = (pwr_q == pph_pkg::PS_PORWAIT);
  assign sleeping = holdNow;

  // ==========================================================
  // Macrocells
  // ==========================================================
  // Clock pin edge, taken from the kept and synchronised level
  always_ff @(posedge mclk) begin
    if (srst) begin
      clkPrev_q <= 1'b0;
    end else if (!holdNow) begin
      clkPrev_q <= keptIn[pph_pkg::CLK_PIN_IDX];
    end
  end

  assign clkEdge = keptIn[pph_pkg::CLK_PIN_IDX] & ~clkPrev_q;

  // Registers clear at reset and advance only outside hold
  always_ff @(posedge mclk) begin
    if (srst) begin
      mcReg_q <= '0;
    end else if (clkEdge && !holdNow && !porBusy) begin
      mcReg_q <= sumTerm;
    end
  end

  // Output form: registered or combinational, then polarity
  assign pathVal = (mcCfg_q.registered & mcReg_q) | (~mcCfg_q.registered & sumTerm);

  // Outputs freeze whole during hold, including undriven ones
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_q <= mcCfg_q.activeLow;
      oeN_q <= '1;
    end else if (!holdNow) begin
      out_q <= pathVal ^ mcCfg_q.activeLow;
      oeN_q <= ~oeTerm;
    end
  end

  assign ioOut = out_q;
  assign ioOe_n = oeN_q;

  // Buried feedback stays usable in sleep mode
  assign feedback = (mcCfg_q.registered & mcReg_q) | (~mcCfg_q.registered & keptIo);

  // Shared pin is cut from the array when it serves as sleep pin
  always_comb begin
    arrIn = keptIn;
    if (ctrl_q.sleepEn) begin
      arrIn[pph_pkg::SHARED_PIN_IDX] = 1'b0;
    end
  end

  assign arrayIn = {feedback, arrIn};

  // ==========================================================
  // Register bus: write path
  // ==========================================================
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrHit = (awAddr_q == pph_pkg::CTRL_OFS) || (awAddr_q == pph_pkg::MCFG_OFS) ||
                 (awAddr_q == pph_pkg::SIGLO_OFS) || (awAddr_q == pph_pkg::SIGHI_OFS) ||
                 (awAddr_q == pph_pkg::STAT_OFS);

  // Take address and data in either order, answer once both are in
  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bValid_q <= 1'b0;
      bResp_q <= pph_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= wrHit ? pph_pkg::RESP_OKAY : pph_pkg::RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  // Control bits: sleep select defaults clear, security only sets
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= '0;
    end else if (doWrite && awAddr_q == pph_pkg::CTRL_OFS && wStrb_q[0]) begin
      ctrl_q.sleepEn <= wData_q[pph_pkg::CTRL_SLEEP_EN_BIT];
      ctrl_q.secure <= ctrl_q.secure | wData_q[pph_pkg::CTRL_SECURE_BIT];
    end
  end

  // Current output forms as a word, with the held write merged per byte
  always_comb begin
    mcfgOld = '0;
    mcfgOld[pph_pkg::MCFG_POL_LSB +: pph_pkg::NUM_MC] = mcCfg_q.activeLow;
    mcfgOld[pph_pkg::MCFG_REG_LSB +: pph_pkg::NUM_MC] = mcCfg_q.registered;
    mcfgNew = mergeBytes(mcfgOld, wData_q, wStrb_q);
  end

  // Macrocell output forms
  always_ff @(posedge mclk) begin
    if (srst) begin
      mcCfg_q <= '0;
    end else if (doWrite && awAddr_q == pph_pkg::MCFG_OFS) begin
      mcCfg_q.activeLow <= mcfgNew[pph_pkg::MCFG_POL_LSB +: pph_pkg::NUM_MC];
      mcCfg_q.registered <= mcfgNew[pph_pkg::MCFG_REG_LSB +: pph_pkg::NUM_MC];
    end
  end

  // User signature words
  always_ff @(posedge mclk) begin
    if (srst) begin
      sig_q <= {pph_pkg::SIG_RESET, pph_pkg::SIG_RESET};
    end else if (doWrite && awAddr_q == pph_pkg::SIGLO_OFS) begin
      sig_q[31:0] <= mergeBytes(sig_q[31:0], wData_q, wStrb_q);
    end else if (doWrite && awAddr_q == pph_pkg::SIGHI_OFS) begin
      sig_q[63:32] <= mergeBytes(sig_q[63:32], wData_q, wStrb_q);
    end
  end

  // ==========================================================
  // Register bus: read path
  // ==========================================================
  // Configuration reads as zero once secured; signature never hidden
  always_comb begin
    rdMux = '0;
    rdHit = 1'b1;
    case (s_axi_araddr)
      pph_pkg::CTRL_OFS: begin
        rdMux[pph_pkg::CTRL_SLEEP_EN_BIT] = ctrl_q.sleepEn & ~ctrl_q.secure;
        rdMux[pph_pkg::CTRL_SECURE_BIT] = ctrl_q.secure;
      end
      pph_pkg::MCFG_OFS: begin
        if (!ctrl_q.secure) begin
          rdMux[pph_pkg::MCFG_POL_LSB +: pph_pkg::NUM_MC] = mcCfg_q.activeLow;
          rdMux[pph_pkg::MCFG_REG_LSB +: pph_pkg::NUM_MC] = mcCfg_q.registered;
        end
      end
      pph_pkg::SIGLO_OFS: rdMux = sig_q[31:0];
      pph_pkg::SIGHI_OFS: rdMux = sig_q[63:32];
      pph_pkg::STAT_OFS: begin
        rdMux[pph_pkg::STAT_SLEEP_BIT] = holdNow;
        rdMux[pph_pkg::STAT_POR_BIT] = porBusy;
        rdMux[pph_pkg::STAT_OUT_LSB +: pph_pkg::NUM_MC] = out_q;
      end
      default: rdHit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rValid_q;

  // One read at a time, answered the cycle after it is taken
  always_ff @(posedge mclk) begin
    if (srst) begin
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= pph_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q <= rdMux;
      rResp_q <= rdHit ? pph_pkg::RESP_OKAY : pph_pkg::RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // ==========================================================
  // Checks
  // ==========================================================
  enterSleep_a: assert property (@(posedge mclk) disable iff (srst)
    (pwr_q == pph_pkg::PS_RUN && sleepReq) |=> holdNow) else $error("sleep not entered");
  outFrozen_a: assert property (@(posedge mclk) disable iff (srst)
    holdNow ##1 holdNow |-> $stable(ioOut)) else $error("output moved in hold");
  regFrozen_a: assert property (@(posedge mclk) disable iff (srst)
    holdNow |=> $stable(mcReg_q)) else $error("register moved in hold");
  oeFrozen_a: assert property (@(posedge mclk) disable iff (srst)
    holdNow ##1 holdNow |-> $stable(ioOe_n)) else $error("enable moved in hold");
  inputsBlocked_a: assert property (@(posedge mclk) disable iff (srst)
    holdNow |=> $stable(arrIn)) else $error("input reached array in hold");
  sharedPlain_a: assert property (@(posedge mclk) disable iff (srst)
    !ctrl_q.sleepEn |-> arrayIn[pph_pkg::SHARED_PIN_IDX] == keptIn[pph_pkg::SHARED_PIN_IDX])
    else $error("shared pin not an input");
  sharedCut_a: assert property (@(posedge mclk) disable iff (srst)
    ctrl_q.sleepEn |-> !arrayIn[pph_pkg::SHARED_PIN_IDX]) else $error("shared pin fed array");
  secureHide_a: assert property (@(posedge mclk) disable iff (srst)
    (s_axi_arvalid && s_axi_arready && ctrl_q.secure && s_axi_araddr == pph_pkg::MCFG_OFS)
    |=> s_axi_rdata == 32'h0000_0000) else $error("config leaked when secure");
  porClear_a: assert property (@(posedge mclk)
    srst |=> mcReg_q == '0 && porBusy) else $error("registers not cleared");
  resumeClock_a: assert property (@(posedge mclk) disable iff (srst)
    (clkEdge && !holdNow && !porBusy) |=> mcReg_q == $past(sumTerm))
    else $error("register did not resume");
endmodule : pph_top
`default_nettype wire
